//--- pcws_top.sv
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Functional notes
// - 28 pins, each with own direction
// - Per-pin output drive standard or high
// - Per-pin pull-up, pull-down or none
// - Per-pin level wake with chosen polarity
// - Six analog channels through one multiplexer
// - Resolution 8/9/10 bits, scaling 1/1,2/3,1/3
// - Power-on alone releases device from reset; here the reset pin going high releases it too
// - Strap low run mode, high development
// - Pins come up as digital inputs
// - Default inputs have no pull bias
// - Receive pin defaults to weak pull-up
// - Clear-to-send pin defaults to pull-down
// - Peripheral select driven from any output pin
module pcws_top #(
   parameter int unsigned HWRST_CYC = pcws_pkg::PCWS_HWRST_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [27:0] shared_io_pin_i,
   output logic [27:0] shared_io_pin_o,
   output logic [27:0] shared_io_pin_oe_o,
   output logic [27:0] pin_high_drive_o,
   output logic [27:0] pin_pull_up_o,
   output logic [27:0] pin_pull_down_o,
   output logic [5:0] analog_input_sel_o,
   output logic [1:0] adc_resolution_o,
   output logic [1:0] adc_scaling_o,
   input wire logic hw_reset_low_i,
   input wire logic mode_select_strap_i,
   output logic hw_reset_o,
   output logic run_mode_o,
   output logic mode_valid_o,
   output logic wake_req_o
);
   typedef struct packed {
      pcws_pkg::pcws_pins_s pins;
      pcws_pkg::pcws_adc_s adc;
      pcws_pkg::pcws_mode_e mode;
      logic mode_valid;
      logic [1:0] fill;
      logic [23:0] rst_cnt;
      logic hwrst_seen;
      logic ack;
      logic [31:0] dat;
   } pcws_state_s;

   localparam logic [23:0] RST_LIMIT = 24'(HWRST_CYC);
   localparam logic [1:0] FILL_DONE = 2'(pcws_pkg::PCWS_SYNC_FILL);

   pcws_state_s st;
   pcws_state_s next_st;
   logic [29:0] sync_q;
   logic [27:0] pin_s;
   logic rst_pin_low;
   logic strap_s;
   logic hw_rst_hold;
   logic [27:0] wake_hit;
   logic bus_req;
   logic bus_wr;

   pcws_sync #(
      .WIDTH(30)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({mode_select_strap_i, ~hw_reset_low_i, shared_io_pin_i}),
      .q_o(sync_q)
   );

   assign pin_s = sync_q[27:0];
   assign rst_pin_low = sync_q[28];
   assign strap_s = sync_q[29];
   assign hw_rst_hold = (st.rst_cnt == RST_LIMIT);

   // Byte-lane merge for a 28-bit register
   function automatic logic [27:0] merge28(input logic [27:0] old, input logic [31:0] wd,
                                           input logic [3:0] sel);
      logic [31:0] r;
      r = {4'h0, old};
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r[27:0];
   endfunction

   // Word index check, used for writes and reads
   function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
      return adr[7:2] == ofs[7:2];
   endfunction

   // Pull bias: both bits set means no bias, so a half-written pair never fights
   function automatic logic [1:0] bias(input logic up, input logic dn);
      return {up & ~dn, dn & ~up};
   endfunction

   assign wake_hit = st.pins.wen & ~(pin_s ^ st.pins.wpol);
   assign bus_req = wb_cyc_i & wb_stb_i & ~st.ack;
   assign bus_wr = bus_req & wb_we_i;

   always_comb begin
      logic [2:0] ch;
      logic [1:0] rs;
      logic [1:0] sc;
      ch = wb_dat_i[pcws_pkg::PCWS_ADC_CHAN_LSB +: 3];
      rs = wb_dat_i[pcws_pkg::PCWS_ADC_RES_LSB +: 2];
      sc = wb_dat_i[pcws_pkg::PCWS_ADC_SCALE_LSB +: 2];
      next_st = st;
      next_st.ack = bus_req;
      next_st.fill = (st.fill == FILL_DONE) ? st.fill : st.fill + 2'h1;

      // Reset pin must stay low the full minimum time to count
      if (rst_pin_low) begin
         if (!hw_rst_hold) begin
            next_st.rst_cnt = st.rst_cnt + 24'h00_0001;
         end
      end else begin
         next_st.rst_cnt = 24'h00_0000;
      end

      // Strap taken once when the synchroniser holds a real sample
      if (!st.mode_valid && st.fill == FILL_DONE && !hw_rst_hold) begin
         next_st.mode = strap_s ? pcws_pkg::PCWS_MODE_DEV : pcws_pkg::PCWS_MODE_RUN;
         next_st.mode_valid = 1'b1;
      end

      if (bus_wr) begin
         if (hit(wb_adr_i, pcws_pkg::PCWS_DIR_OFS)) begin
            next_st.pins.dir = merge28(st.pins.dir, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_OUT_OFS)) begin
            next_st.pins.out = merge28(st.pins.out, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_DRV_OFS)) begin
            next_st.pins.drv = merge28(st.pins.drv, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_PU_OFS)) begin
            next_st.pins.pu = merge28(st.pins.pu, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_PD_OFS)) begin
            next_st.pins.pd = merge28(st.pins.pd, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_WEN_OFS)) begin
            next_st.pins.wen = merge28(st.pins.wen, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_WPOL_OFS)) begin
            next_st.pins.wpol = merge28(st.pins.wpol, wb_dat_i, wb_sel_i);
         end
         // Illegal channel, resolution or scaling leaves the whole word unchanged
         if (hit(wb_adr_i, pcws_pkg::PCWS_ADC_OFS) && wb_sel_i[0] && wb_sel_i[1]) begin
            if (ch < 3'(pcws_pkg::PCWS_NCHAN) && rs != 2'h3 && sc != 2'h3) begin
               next_st.adc.en = wb_dat_i[pcws_pkg::PCWS_ADC_EN_BIT];
               next_st.adc.chan = ch;
               next_st.adc.res = rs;
               next_st.adc.scale = sc;
            end
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_STAT_OFS) && wb_sel_i[0] &&
             wb_dat_i[pcws_pkg::PCWS_ST_HWRST_BIT]) begin
            next_st.hwrst_seen = 1'b0;
         end
      end

      next_st.dat = 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
         if (hit(wb_adr_i, pcws_pkg::PCWS_DIR_OFS)) begin
            next_st.dat = {4'h0, st.pins.dir};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_OUT_OFS)) begin
            next_st.dat = {4'h0, st.pins.out};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_DRV_OFS)) begin
            next_st.dat = {4'h0, st.pins.drv};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_PU_OFS)) begin
            next_st.dat = {4'h0, st.pins.pu};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_PD_OFS)) begin
            next_st.dat = {4'h0, st.pins.pd};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_WEN_OFS)) begin
            next_st.dat = {4'h0, st.pins.wen};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_WPOL_OFS)) begin
            next_st.dat = {4'h0, st.pins.wpol};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_IN_OFS)) begin
            next_st.dat = {4'h0, pin_s};
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_ADC_OFS)) begin
            next_st.dat[pcws_pkg::PCWS_ADC_EN_BIT] = st.adc.en;
            next_st.dat[pcws_pkg::PCWS_ADC_CHAN_LSB +: 3] = st.adc.chan;
            next_st.dat[pcws_pkg::PCWS_ADC_RES_LSB +: 2] = st.adc.res;
            next_st.dat[pcws_pkg::PCWS_ADC_SCALE_LSB +: 2] = st.adc.scale;
         end
         if (hit(wb_adr_i, pcws_pkg::PCWS_STAT_OFS)) begin
            next_st.dat[pcws_pkg::PCWS_ST_MODE_BIT] = (st.mode == pcws_pkg::PCWS_MODE_DEV);
            next_st.dat[pcws_pkg::PCWS_ST_VALID_BIT] = st.mode_valid;
            next_st.dat[pcws_pkg::PCWS_ST_WAKE_BIT] = |wake_hit;
            next_st.dat[pcws_pkg::PCWS_ST_HWRST_BIT] = st.hwrst_seen;
         end
      end

      // A recognised pin reset returns the pins to defaults and retakes the strap
      if (hw_rst_hold) begin
         next_st.pins = '{dir: pcws_pkg::PCWS_DIR_RST, out: pcws_pkg::PCWS_OUT_RST,
                          drv: pcws_pkg::PCWS_DRV_RST, pu: pcws_pkg::PCWS_PU_RST,
                          pd: pcws_pkg::PCWS_PD_RST, wen: pcws_pkg::PCWS_WEN_RST,
                          wpol: pcws_pkg::PCWS_WPOL_RST};
         next_st.adc = '{en: 1'b0, chan: pcws_pkg::PCWS_ADC_CHAN_RST,
                         res: pcws_pkg::PCWS_RES_10, scale: pcws_pkg::PCWS_SCALE_1_1};
         next_st.mode_valid = 1'b0;
         next_st.fill = 2'h0;
         // Set wins over a clear arriving in the same cycle
         next_st.hwrst_seen = 1'b1;
      end
   end

   // Power-on reset alone brings every field to its default
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.pins.dir <= pcws_pkg::PCWS_DIR_RST;
         st.pins.out <= pcws_pkg::PCWS_OUT_RST;
         st.pins.drv <= pcws_pkg::PCWS_DRV_RST;
         st.pins.pu <= pcws_pkg::PCWS_PU_RST;
         st.pins.pd <= pcws_pkg::PCWS_PD_RST;
         st.pins.wen <= pcws_pkg::PCWS_WEN_RST;
         st.pins.wpol <= pcws_pkg::PCWS_WPOL_RST;
         st.adc.en <= 1'b0;
         st.adc.chan <= pcws_pkg::PCWS_ADC_CHAN_RST;
         st.adc.res <= pcws_pkg::PCWS_RES_10;
         st.adc.scale <= pcws_pkg::PCWS_SCALE_1_1;
         st.mode <= pcws_pkg::PCWS_MODE_RUN;
         st.mode_valid <= 1'b0;
         st.fill <= 2'h0;
         st.rst_cnt <= 24'h00_0000;
         st.hwrst_seen <= 1'b0;
         st.ack <= 1'b0;
         st.dat <= 32'h0000_0000;
      end else begin
         st <= next_st;
      end
   end

   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.dat;
   assign shared_io_pin_o = st.pins.out;
   assign shared_io_pin_oe_o = st.pins.dir;
   assign pin_high_drive_o = st.pins.drv & st.pins.dir;

   for (genvar g = 0; g < 28; g++) begin : g_bias
      assign {pin_pull_up_o[g], pin_pull_down_o[g]} = bias(st.pins.pu[g], st.pins.pd[g]);
   end

   for (genvar c = 0; c < 6; c++) begin : g_mux
      assign analog_input_sel_o[c] = st.adc.en && (st.adc.chan == 3'(c));
   end

   assign adc_resolution_o = st.adc.res;
   assign adc_scaling_o = st.adc.scale;
   assign hw_reset_o = hw_rst_hold;
   assign run_mode_o = st.mode_valid && (st.mode == pcws_pkg::PCWS_MODE_RUN);
   assign mode_valid_o = st.mode_valid;
   assign wake_req_o = |wake_hit;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_pin_low_held;
      rst_pin_low ##1 rst_pin_low;
   endsequence

   sequence s_mode_taken;
      !mode_valid_o ##1 mode_valid_o;
   endsequence

   a_ack_one_cycle: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack did not follow request for one cycle");

   a_oe_follows_dir: assert property (
      (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == pcws_pkg::PCWS_DIR_OFS &&
       $past(wb_sel_i) == 4'hF && !$past(hw_rst_hold))
      |-> shared_io_pin_oe_o == $past(wb_dat_i[27:0]))
      else $error("direction write not reflected on enables");

   a_drive_needs_out: assert property (
      (pin_high_drive_o & ~shared_io_pin_oe_o) == 28'h000_0000)
      else $error("high drive on an input pin");

   a_bias_exclusive: assert property (
      (pin_pull_up_o & pin_pull_down_o) == 28'h000_0000)
      else $error("pull-up and pull-down together");

   a_wake_match: assert property (
      wake_req_o == |(st.pins.wen & ~($past(shared_io_pin_i, 2) ^ st.pins.wpol)))
      else $error("wake request does not match enabled pin levels");

   a_mux_onehot: assert property (
      $onehot0(analog_input_sel_o) && (st.adc.res != 2'h3) && (st.adc.scale != 2'h3))
      else $error("analog select or converter setting illegal");

   a_strap_mode: assert property (
      s_mode_taken |-> run_mode_o == !$past(strap_s))
      else $error("mode does not match sampled strap");

   a_mode_held: assert property (
      (mode_valid_o && !hw_reset_o) |=> mode_valid_o && $stable(run_mode_o))
      else $error("mode changed without reset");

   a_reset_short: assert property (
      s_pin_low_held |-> st.rst_cnt == ($past(hw_reset_o) ? RST_LIMIT :
                                        $past(st.rst_cnt) + 24'h00_0001))
      else $error("reset low time not counted cycle by cycle");

   a_reset_rise: assert property (
      $rose(hw_reset_o) |-> $past(rst_pin_low) && $past(st.rst_cnt) == RST_LIMIT - 24'h00_0001)
      else $error("pin reset recognised before the low time ran out");

   a_reset_defaults: assert property (
      hw_reset_o |=> shared_io_pin_oe_o == pcws_pkg::PCWS_DIR_RST &&
                     pin_pull_up_o == pcws_pkg::PCWS_PU_RST &&
                     pin_pull_down_o == pcws_pkg::PCWS_PD_RST)
      else $error("pin defaults not restored after reset");

   a_no_reset_idle: assert property (
      !rst_pin_low |=> !hw_reset_o)
      else $error("reset asserted with pin high");
endmodule

//--- pcws_pkg.sv
package pcws_pkg;

   localparam int unsigned PCWS_NPINS = 28;
   localparam int unsigned PCWS_NCHAN = 6;

   // Wishbone word addresses (byte offsets)
   localparam logic [7:0] PCWS_DIR_OFS = 8'h00;
   localparam logic [7:0] PCWS_OUT_OFS = 8'h04;
   localparam logic [7:0] PCWS_DRV_OFS = 8'h08;
   localparam logic [7:0] PCWS_PU_OFS = 8'h0C;
   localparam logic [7:0] PCWS_PD_OFS = 8'h10;
   localparam logic [7:0] PCWS_WEN_OFS = 8'h14;
   localparam logic [7:0] PCWS_WPOL_OFS = 8'h18;
   localparam logic [7:0] PCWS_IN_OFS = 8'h1C;
   localparam logic [7:0] PCWS_ADC_OFS = 8'h20;
   localparam logic [7:0] PCWS_STAT_OFS = 8'h24;

   // Pin defaults after reset
   localparam logic [27:0] PCWS_DIR_RST = 28'h000_0000;
   localparam logic [27:0] PCWS_OUT_RST = 28'h000_0000;
   localparam logic [27:0] PCWS_DRV_RST = 28'h000_0000;
   localparam int unsigned PCWS_RX_PIN = 22;
   localparam int unsigned PCWS_CTS_PIN = 24;
   localparam logic [27:0] PCWS_PU_RST = 28'h040_0000;
   localparam logic [27:0] PCWS_PD_RST = 28'h100_0000;
   localparam logic [27:0] PCWS_WEN_RST = 28'h000_0000;
   localparam logic [27:0] PCWS_WPOL_RST = 28'h000_0000;

   // Converter configuration field positions
   localparam int unsigned PCWS_ADC_EN_BIT = 0;
   localparam int unsigned PCWS_ADC_CHAN_LSB = 4;
   localparam int unsigned PCWS_ADC_RES_LSB = 8;
   localparam int unsigned PCWS_ADC_SCALE_LSB = 12;
   localparam logic [2:0] PCWS_ADC_CHAN_RST = 3'h0;
   localparam logic [1:0] PCWS_RES_8 = 2'h0;
   localparam logic [1:0] PCWS_RES_9 = 2'h1;
   localparam logic [1:0] PCWS_RES_10 = 2'h2;
   localparam logic [1:0] PCWS_SCALE_1_1 = 2'h0;
   localparam logic [1:0] PCWS_SCALE_2_3 = 2'h1;
   localparam logic [1:0] PCWS_SCALE_1_3 = 2'h2;

   // Status field positions
   localparam int unsigned PCWS_ST_MODE_BIT = 0;
   localparam int unsigned PCWS_ST_VALID_BIT = 1;
   localparam int unsigned PCWS_ST_WAKE_BIT = 2;
   localparam int unsigned PCWS_ST_HWRST_BIT = 3;

   // Hardware reset pin minimum low time
   localparam int unsigned PCWS_CLK_KHZ = 100000;
   localparam int unsigned PCWS_HWRST_MS = 100;
   localparam int unsigned PCWS_HWRST_CYC = PCWS_HWRST_MS * PCWS_CLK_KHZ;
   localparam int unsigned PCWS_SYNC_FILL = 2;

   typedef enum logic {
      PCWS_MODE_RUN,
      PCWS_MODE_DEV
   } pcws_mode_e;

   typedef struct packed {
      logic [27:0] dir;
      logic [27:0] out;
      logic [27:0] drv;
      logic [27:0] pu;
      logic [27:0] pd;
      logic [27:0] wen;
      logic [27:0] wpol;
   } pcws_pins_s;

   typedef struct packed {
      logic en;
      logic [2:0] chan;
      logic [1:0] res;
      logic [1:0] scale;
   } pcws_adc_s;

endpackage

//--- pcws_sync.sv
`timescale 1ns/1ps
module pcws_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule

//--- pcws_board.sv
`timescale 1ns/1ps
module pcws_board (
   input wire logic clk_i,
   input wire logic [27:0] dev_oe_i,
   input wire logic [27:0] dev_out_i,
   input wire logic [27:0] pull_up_i,
   input wire logic [27:0] pull_down_i,
   input wire logic [27:0] ext_en_i,
   input wire logic [27:0] ext_val_i,
   input wire logic strap_i,
   input wire logic [7:0] rst_len_i,
   input wire logic rst_go_i,
   output logic [27:0] pin_o,
   output logic hw_reset_low_o,
   output logic strap_o
);
   logic [27:0] float_pat = 28'h000_0000;
   logic [7:0] rst_cnt = 8'h00;
   logic [27:0] up;
   logic [27:0] dn;
   assign up = pull_up_i & ~pull_down_i;
   assign dn = pull_down_i & ~pull_up_i;
   // Unbiased released pins toggle each cycle so a stale level never passes for a real one
   always @(posedge clk_i) begin
      float_pat <= ~float_pat;
      if (rst_go_i) begin
         rst_cnt <= rst_len_i;
      end else if (rst_cnt != 8'h00) begin
         rst_cnt <= rst_cnt - 8'h01;
      end
   end
   assign pin_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_en_i & ext_val_i)
      | (~dev_oe_i & ~ext_en_i & (up | (~dn & float_pat)));
   // Low time is whatever the bench commands, so a short pulse can be tried too
   assign hw_reset_low_o = (rst_cnt == 8'h00);
   assign strap_o = strap_i;
endmodule

//--- pcws_top_test.sv
`timescale 1ns/1ps
module pcws_top_test;
   logic clk, rst, cyc, stb, we, strap, rst_go, hw_rst_low, strap_pin;
   logic ack, hw_rst, run_mode, mode_valid, wake;
   logic [7:0] adr, rst_len;
   logic [3:0] sel;
   logic [31:0] dat_w, rdat;
   logic [27:0] pin_in, pin_o, oe, hdrv, pu_o, pd_o, ext_en, ext_val;
   logic [5:0] analog_input;
   logic [1:0] res, scale;
   int fail_count = 0;
   int total_checks = 0;

   pcws_top #(.HWRST_CYC(20)) DUT (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(rdat), .wb_ack_o(ack),
      .shared_io_pin_i(pin_in), .shared_io_pin_o(pin_o), .shared_io_pin_oe_o(oe),
      .pin_high_drive_o(hdrv), .pin_pull_up_o(pu_o), .pin_pull_down_o(pd_o),
      .analog_input_sel_o(analog_input), .adc_resolution_o(res), .adc_scaling_o(scale),
      .hw_reset_low_i(hw_rst_low), .mode_select_strap_i(strap_pin), .hw_reset_o(hw_rst),
      .run_mode_o(run_mode), .mode_valid_o(mode_valid), .wake_req_o(wake));

   pcws_board board (
      .clk_i(clk), .dev_oe_i(oe), .dev_out_i(pin_o), .pull_up_i(pu_o), .pull_down_i(pd_o),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .strap_i(strap), .rst_len_i(rst_len),
      .rst_go_i(rst_go), .pin_o(pin_in), .hw_reset_low_o(hw_rst_low), .strap_o(strap_pin));

   task automatic conclude();
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // The master waits for ack with no assumed latency; only the watchdog bounds it
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= s;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0000_0000, 4'hF, q);
      chk_vec(q, exp);
   endtask

   task automatic t_defaults();
      wt(6);
      chk_vec(32'(oe), 32'h0000_0000);
      chk_vec(32'(pu_o), 32'(pcws_pkg::PCWS_PU_RST));
      chk_vec(32'(pd_o), 32'(pcws_pkg::PCWS_PD_RST));
      chk_bit(hw_rst, 1'b0);
      chk_bit(mode_valid, 1'b1);
      chk_bit(run_mode, 1'b1);
      chk_vec(32'({analog_input, res, scale}), 32'h0000_0008);
      rdc(pcws_pkg::PCWS_DIR_OFS, 32'h0000_0000);
      rdc(pcws_pkg::PCWS_PU_OFS, 32'(pcws_pkg::PCWS_PU_RST));
      rdc(pcws_pkg::PCWS_PD_OFS, 32'(pcws_pkg::PCWS_PD_RST));
      rdc(pcws_pkg::PCWS_STAT_OFS, 32'h0000_0002);
      rdc(8'h3C, 32'h0000_0000);
   endtask

   task automatic t_dir();
      wr(pcws_pkg::PCWS_DIR_OFS, 32'h05A5_A5A5);
      wr(pcws_pkg::PCWS_OUT_OFS, 32'h0FFF_0F0F);
      ext_en <= 28'hA5A_5A5A;
      ext_val <= 28'h123_4567;
      wt(4);
      chk_vec(32'(oe), 32'h05A5_A5A5);
      chk_vec(32'(pin_o), 32'h0FFF_0F0F);
      rdc(pcws_pkg::PCWS_IN_OFS, 32'((28'h5A5_A5A5 & 28'hFFF_0F0F)
         | (28'hA5A_5A5A & 28'h123_4567)));
      wr(pcws_pkg::PCWS_OUT_OFS, 32'h0FFF_0E0F);
      wt(1);
      chk_vec(32'(pin_in & 28'h5A5_A5A5), 32'h05A5_0405);
   endtask

   task automatic t_drive_pull();
      logic [31:0] q;
      wr(pcws_pkg::PCWS_DRV_OFS, 32'h0FFF_FFFF);
      wt(1);
      chk_vec(32'(hdrv), 32'h05A5_A5A5);
      wr(pcws_pkg::PCWS_DIR_OFS, 32'h0000_0000);
      ext_en <= 28'h000_0000;
      wr(pcws_pkg::PCWS_PU_OFS, 32'h00FF_F0F0);
      wr(pcws_pkg::PCWS_PD_OFS, 32'h0F0F_FF00);
      wt(4);
      chk_vec(32'(hdrv), 32'h0000_0000);
      chk_vec(32'(pu_o), 32'h00F0_00F0);
      chk_vec(32'(pd_o), 32'h0F00_0F00);
      wb(1'b0, pcws_pkg::PCWS_IN_OFS, 32'h0000_0000, 4'hF, q);
      chk_vec(q & 32'h0FF0_0FF0, 32'h00F0_00F0);
   endtask

   task automatic t_wake();
      wr(pcws_pkg::PCWS_WPOL_OFS, 32'h0AAA_AAAA);
      ext_en <= 28'hFFF_FFFF;
      ext_val <= 28'hAAA_AAAA;
      wr(pcws_pkg::PCWS_WEN_OFS, 32'h0000_0000);
      wt(4);
      chk_bit(wake, 1'b0);
      for (int i = 0; i < 28; i++) begin
         wr(pcws_pkg::PCWS_WEN_OFS, 32'h0000_0001 << i);
         ext_val <= 28'h555_5555;
         wt(4);
         chk_bit(wake, 1'b0);
         @(posedge clk);
         ext_val <= 28'h555_5555 ^ (28'h000_0001 << i);
         wt(3);
         chk_bit(wake, 1'b1);
      end
   endtask

   task automatic t_adc();
      logic [31:0] d;
      for (int c = 0; c < 6; c++) begin
         d = 32'(((c + 1) % 3) << 12 | (c % 3) << 8 | c << 4 | 1);
         wr(pcws_pkg::PCWS_ADC_OFS, d);
         wt(1);
         chk_vec(32'(analog_input), 32'h0000_0001 << c);
         chk_vec(32'({res, scale}), 32'((c % 3) << 2 | (c + 1) % 3));
         rdc(pcws_pkg::PCWS_ADC_OFS, d);
      end
      // A seventh channel does not exist, so the write must leave channel 5 in place
      wr(pcws_pkg::PCWS_ADC_OFS, 32'h0000_0261);
      wt(1);
      chk_vec(32'(analog_input), 32'h0000_0020);
      wr(pcws_pkg::PCWS_ADC_OFS, 32'h0000_0000);
      wt(1);
      chk_vec(32'(analog_input), 32'h0000_0000);
   endtask

   task automatic t_strap_reset();
      logic [31:0] q;
      int n;
      wr(pcws_pkg::PCWS_DIR_OFS, 32'h0000_0001);
      strap <= 1'b1;
      rst_len <= 8'h08;
      rst_go <= 1'b1;
      @(posedge clk);
      rst_go <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         wt(1);
         chk_bit(hw_rst, 1'b0);
      end
      chk_bit(run_mode, 1'b1);
      rdc(pcws_pkg::PCWS_DIR_OFS, 32'h0000_0001);
      rst_len <= 8'h1E;
      rst_go <= 1'b1;
      @(posedge clk);
      rst_go <= 1'b0;
      n = 0;
      while (hw_rst !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk_bit(n >= 20 && n <= 26, 1'b1);
      wt(20);
      chk_bit(hw_rst, 1'b0);
      chk_bit(mode_valid, 1'b1);
      chk_bit(run_mode, 1'b0);
      rdc(pcws_pkg::PCWS_DIR_OFS, 32'h0000_0000);
      rdc(pcws_pkg::PCWS_STAT_OFS, 32'h0000_000B);
      wb(1'b1, pcws_pkg::PCWS_STAT_OFS, 32'h0000_0008, 4'h1, q);
      rdc(pcws_pkg::PCWS_STAT_OFS, 32'h0000_0003);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      rst = 1'b1;
      {cyc, stb, we, strap, rst_go} = 5'h00;
      adr = 8'h00;
      rst_len = 8'h00;
      sel = 4'h0;
      dat_w = 32'h0000_0000;
      ext_en = 28'h000_0000;
      ext_val = 28'h000_0000;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_dir();
      t_drive_pull();
      t_wake();
      t_adc();
      t_strap_reset();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
